// ===== logic/drive_psm.sv
// drive power state machine with APB register access and interrupt
// assumes: one 100 MHz clock, external status pins asynchronous to it
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ns

module drive_psm
	import drive_psm_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic SELFTEST_OK,
	input wire logic FATAL_ERR,
	input wire logic FAULT_IN,
	input wire logic LIMIT_SW,
	input wire logic MOTOR_STOPPED,
	output logic POWER_EN,
	output logic CTRL_EN,
	output logic [1:0] RAMP_SEL,
	output logic HALT_ACT,
	output logic IRQ
);
	// ---------------------------------------------------------------
	// state record
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [4:0] sync1;
		logic [4:0] sync2;
		drive_state_t state;
		logic fatal;
		logic [15:0] cmd;
		logic [15:0] cmd_prev;
		logic [7:0] mode_req;
		logic [7:0] mode_act;
		logic [15:0] qs_opt;
		logic [15:0] sd_opt;
		logic [15:0] halt_opt;
		logic [15:0] fault_opt;
		logic sd_brake;
		logic [1:0] ramp;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_mask;
		logic [31:0] rdata;
	} regs_t;

	regs_t r_q;
	regs_t r_d;

	// ---------------------------------------------------------------
	// decode helpers
	// ---------------------------------------------------------------
	function automatic drive_cmd_t decode_cmd(input logic [15:0] c);
		drive_cmd_t res;
		res = C_NONE;
		if (!c[7]) begin
			if (!c[1])
				res = C_DIS_VOLT;
			else if (!c[2])
				res = C_QSTOP;
			else if (!c[0])
				res = C_SHUTDOWN;
			else if (c[3])
				res = C_ENABLE_OP;
			else
				res = C_SWITCH_ON;
		end
		return res;
	endfunction : decode_cmd

	function automatic logic [1:0] opt_ramp(input logic [15:0] o);
		logic [1:0] res;
		res = RAMP_NONE;
		if (o == OPT_1 || o == OPT_5)
			res = RAMP_DECEL;
		else if (o == OPT_2 || o == OPT_6)
			res = RAMP_QUICK;
		return res;
	endfunction : opt_ramp

	function automatic logic [15:0] status_of(input drive_state_t s, input logic volt,
			input logic halt);
		logic [15:0] w;
		w = 16'h0000;
		case (s)
			S_NOT_READY: w = 16'h0000;
			S_SW_DISABLED: w = 16'h0040;
			S_READY: w = 16'h0021;
			S_SWITCHED_ON: w = 16'h0023;
			S_OP_ENABLED: w = 16'h0027;
			S_QSTOP: w = 16'h0007;
			S_FAULT_REACT: w = 16'h000F;
			S_FAULT: w = 16'h0008;
			default: w = 16'h0000;
		endcase
		w[ST_VOLT_BIT] = volt;
		w[ST_HALT_BIT] = halt;
		return w;
	endfunction : status_of

	// ---------------------------------------------------------------
	// synchronised inputs and derived terms
	// ---------------------------------------------------------------
	logic st_ok_s, fatal_s, fault_s, limit_s, stopped_s;
	assign st_ok_s = r_q.sync2[0];
	assign fatal_s = r_q.sync2[1];
	assign fault_s = r_q.sync2[2];
	assign limit_s = r_q.sync2[3];
	assign stopped_s = r_q.sync2[4];

	drive_cmd_t cmd_dec;
	logic fr_edge, qs_edge, qs_hold, power_on, halt_on;
	assign cmd_dec = decode_cmd(r_q.cmd);
	// edges are taken between successive command words, so a level never retriggers
	assign fr_edge = r_q.cmd[CMD_FRESET_BIT] & ~r_q.cmd_prev[CMD_FRESET_BIT];
	assign qs_edge = r_q.cmd[CMD_QSTOP_BIT] & ~r_q.cmd_prev[CMD_QSTOP_BIT];
	assign qs_hold = (r_q.qs_opt == OPT_5) || (r_q.qs_opt == OPT_6);
	assign power_on = (r_q.state == S_SWITCHED_ON) || (r_q.state == S_OP_ENABLED) ||
		(r_q.state == S_QSTOP) || (r_q.state == S_FAULT_REACT);
	assign halt_on = r_q.state == S_OP_ENABLED && r_q.cmd[CMD_HALT_BIT];

	logic acc, wr, rd_setup, hit;
	assign acc = PSEL & PENABLE;
	assign wr = acc & PWRITE;
	assign rd_setup = PSEL & ~PENABLE & ~PWRITE;
	assign hit = PADDR[1:0] == 2'h0 && PADDR <= OFS_IRQ_MASK;

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		logic [IRQ_W-1:0] ev;
		logic wr_cmd;
		r_d = r_q;
		ev = '0;
		wr_cmd = wr && PADDR == OFS_CMD;
		r_d.sync1 = {MOTOR_STOPPED, LIMIT_SW, FAULT_IN, FATAL_ERR, SELFTEST_OK};
		r_d.sync2 = r_q.sync1;
		// the edge reference follows the command every cycle, so edges last one cycle
		r_d.cmd_prev = r_q.cmd;
		if (wr_cmd)
			r_d.cmd = PWDATA[15:0];
		// mode in force follows the request every cycle
		r_d.mode_act = r_q.mode_req;

		if (fatal_s || r_q.fatal) begin
			r_d.fatal = 1'b1;
			r_d.state = S_NOT_READY;
			r_d.ramp = RAMP_IMMED;
			r_d.sd_brake = 1'b0;
		end else if (fault_s && r_q.state != S_FAULT_REACT && r_q.state != S_FAULT &&
				r_q.state != S_NOT_READY) begin
			r_d.state = S_FAULT_REACT;
			r_d.ramp = opt_ramp(r_q.fault_opt);
			r_d.sd_brake = 1'b0;
			ev[IRQ_FAULT] = 1'b1;
		end else begin
			case (r_q.state)
				S_NOT_READY: begin
					if (st_ok_s)
						r_d.state = S_SW_DISABLED;
				end
				S_SW_DISABLED: begin
					if (cmd_dec == C_SHUTDOWN)
						r_d.state = S_READY;
				end
				S_READY: begin
					if (r_q.sd_brake) begin
						// shutdown ramp in progress: finish it, then disable
						if (stopped_s) begin
							r_d.state = S_SW_DISABLED;
							r_d.sd_brake = 1'b0;
							r_d.ramp = RAMP_NONE;
						end
					end else if (cmd_dec == C_SWITCH_ON)
						r_d.state = S_SWITCHED_ON;
					else if (cmd_dec == C_DIS_VOLT || cmd_dec == C_QSTOP)
						r_d.state = S_SW_DISABLED;
				end
				S_SWITCHED_ON: begin
					if (cmd_dec == C_ENABLE_OP)
						r_d.state = S_OP_ENABLED;
					else if (cmd_dec == C_SHUTDOWN)
						r_d.state = S_READY;
					else if (cmd_dec == C_DIS_VOLT || cmd_dec == C_QSTOP)
						r_d.state = S_SW_DISABLED;
				end
				S_OP_ENABLED: begin
					r_d.ramp = halt_on ? opt_ramp(r_q.halt_opt) : RAMP_NONE;
					if (limit_s || cmd_dec == C_QSTOP) begin
						r_d.state = S_QSTOP;
						r_d.ramp = r_q.qs_opt == OPT_0 ? RAMP_IMMED : opt_ramp(r_q.qs_opt);
						ev[IRQ_LIMIT] = limit_s;
					end else if (cmd_dec == C_SWITCH_ON)
						r_d.state = S_SWITCHED_ON;
					else if (cmd_dec == C_SHUTDOWN) begin
						r_d.state = S_READY;
						r_d.sd_brake = r_q.sd_opt == OPT_1;
						r_d.ramp = r_q.sd_opt == OPT_1 ? RAMP_DECEL : RAMP_NONE;
					end else if (cmd_dec == C_DIS_VOLT)
						r_d.state = S_SW_DISABLED;
				end
				S_QSTOP: begin
					if (cmd_dec == C_DIS_VOLT) begin
						r_d.state = S_SW_DISABLED;
						r_d.ramp = RAMP_NONE;
					end else if (qs_hold) begin
						// motor stays energized; only a fresh release edge returns
						if (qs_edge && r_q.cmd[3] && r_q.cmd[1] && r_q.cmd[0] && !r_q.cmd[7]) begin
							r_d.state = S_OP_ENABLED;
							r_d.ramp = RAMP_NONE;
						end
					end else if (r_q.ramp == RAMP_IMMED || stopped_s) begin
						r_d.state = S_SW_DISABLED;
						r_d.ramp = RAMP_NONE;
					end
				end
				S_FAULT_REACT: begin
					if (r_q.ramp == RAMP_NONE || stopped_s) begin
						r_d.state = S_FAULT;
						r_d.ramp = RAMP_NONE;
					end
				end
				S_FAULT: begin
					if (fr_edge && !fault_s)
						r_d.state = S_SW_DISABLED;
				end
				default: r_d.state = S_NOT_READY;
			endcase
		end
		// anything not matched above leaves state as it was
		if (r_d.state != r_q.state)
			ev[IRQ_STATE_CHG] = 1'b1;
		if (fatal_s && !r_q.fatal)
			ev[IRQ_FATAL] = 1'b1;

		// register writes; status clear loses against a new event
		if (wr) begin
			case (PADDR)
				OFS_MODE_REQ: r_d.mode_req = PWDATA[7:0];
				OFS_QS_OPT: r_d.qs_opt = PWDATA[15:0];
				OFS_SD_OPT: r_d.sd_opt = PWDATA[15:0];
				OFS_HALT_OPT: r_d.halt_opt = PWDATA[15:0];
				OFS_FAULT_OPT: r_d.fault_opt = PWDATA[15:0];
				OFS_IRQ_MASK: r_d.irq_mask = PWDATA[IRQ_W-1:0];
				default: ;
			endcase
		end
		if (wr && PADDR == OFS_IRQ_STAT)
			r_d.irq_stat = r_q.irq_stat & ~PWDATA[IRQ_W-1:0];
		r_d.irq_stat = r_d.irq_stat | ev;

		// read data is captured in the setup cycle and shown in the access cycle
		if (rd_setup) begin
			case (PADDR)
				OFS_CMD: r_d.rdata = {16'h0000, r_q.cmd};
				OFS_STATE: r_d.rdata = {16'h0000, status_of(r_q.state, power_on, halt_on)};
				OFS_MODE_REQ: r_d.rdata = {24'h000000, r_q.mode_req};
				OFS_MODE_ACT: r_d.rdata = {24'h000000, r_q.mode_act};
				OFS_QS_OPT: r_d.rdata = {16'h0000, r_q.qs_opt};
				OFS_SD_OPT: r_d.rdata = {16'h0000, r_q.sd_opt};
				OFS_HALT_OPT: r_d.rdata = {16'h0000, r_q.halt_opt};
				OFS_FAULT_OPT: r_d.rdata = {16'h0000, r_q.fault_opt};
				OFS_IRQ_STAT: r_d.rdata = {28'h0000000, r_q.irq_stat};
				OFS_IRQ_MASK: r_d.rdata = {28'h0000000, r_q.irq_mask};
				default: r_d.rdata = 32'h00000000;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			r_q <= '0;
			r_q.state <= S_NOT_READY;
			r_q.cmd <= RST_CMD;
			r_q.cmd_prev <= RST_CMD;
			r_q.mode_req <= RST_MODE;
			r_q.mode_act <= RST_MODE;
			r_q.qs_opt <= RST_QS_OPT;
			r_q.sd_opt <= RST_SD_OPT;
			r_q.halt_opt <= RST_HALT_OPT;
			r_q.fault_opt <= RST_FAULT_OPT;
			r_q.ramp <= RAMP_NONE;
		end else begin
			r_q <= r_d;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign PRDATA = r_q.rdata;
	assign PREADY = 1'b1;
	assign PSLVERR = acc & ~hit;
	assign POWER_EN = power_on;
	// control stays on through quick stop and fault reaction braking and while a held quick stop lasts, but is off during the shutdown ramp
	assign CTRL_EN = power_on && r_q.state != S_SWITCHED_ON;
	assign RAMP_SEL = r_q.ramp;
	assign HALT_ACT = halt_on;
	assign IRQ = |(r_q.irq_stat & r_q.irq_mask);

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);

	sequence quiet_s;
		!fatal_s && !r_q.fatal && !fault_s;
	endsequence

	selftest_entry_a: assert property (quiet_s and (r_q.state == S_NOT_READY && st_ok_s) |=>
		r_q.state == S_SW_DISABLED) else $error("self-test pass did not disable");
	fatal_lock_a: assert property (r_q.fatal |-> r_q.state == S_NOT_READY [*3])
		else $error("left not ready after fatal error");
	fault_level_a: assert property (quiet_s and (r_q.state == S_FAULT && !fr_edge) |=>
		r_q.state == S_FAULT) else $error("fault left without reset edge");
	fault_reset_a: assert property (quiet_s and (r_q.state == S_FAULT && fr_edge) |=>
		r_q.state == S_SW_DISABLED) else $error("fault reset edge ignored");
	limit_qstop_a: assert property (quiet_s and (r_q.state == S_OP_ENABLED && limit_s) |=>
		r_q.state == S_QSTOP) else $error("limit switch did not quick stop");
	qs_immed_a: assert property (quiet_s and (r_q.state == S_OP_ENABLED && cmd_dec == C_QSTOP
		&& r_q.qs_opt == OPT_0) |=> r_q.ramp == RAMP_IMMED ##1 r_q.state == S_SW_DISABLED)
		else $error("quick stop option 0 wrong");
	qs_hold_a: assert property (r_q.state == S_QSTOP && qs_hold && cmd_dec != C_DIS_VOLT
		&& !qs_edge && !fault_s && !fatal_s |=> r_q.state == S_QSTOP && POWER_EN)
		else $error("held quick stop released");
	status_oe_a: assert property (r_q.state == S_OP_ENABLED && rd_setup && PADDR == OFS_STATE
		|=> PRDATA[6:5] == 2'b01 && PRDATA[3:0] == 4'h7) else $error("status word wrong");
	status_rtso_a: assert property (r_q.state == S_READY && rd_setup && PADDR == OFS_STATE
		|=> PRDATA[6:5] == 2'b01 && PRDATA[3:0] == 4'h1) else $error("status word wrong");
	no_change_a: assert property (quiet_s and (r_q.state == S_SW_DISABLED &&
		cmd_dec != C_SHUTDOWN) |=> r_q.state == S_SW_DISABLED) else $error("spurious change");
	// the limit status bit may only drop through a write-one-to-clear of that bit
	irq_sticky_a: assert property ($fell(r_q.irq_stat[IRQ_LIMIT]) |-> $past(wr &&
		PADDR == OFS_IRQ_STAT && PWDATA[IRQ_LIMIT])) else $error("interrupt status lost");

	sequence halt_req_s;
		r_q.state == S_OP_ENABLED && cmd_dec == C_ENABLE_OP && r_q.cmd[CMD_HALT_BIT];
	endsequence

	sequence sd_brake_s;
		r_q.state == S_READY && r_q.sd_brake;
	endsequence

	halt_ramp_a: assert property (quiet_s and halt_req_s and (!limit_s &&
		r_q.halt_opt == OPT_1) |=> r_q.ramp == RAMP_DECEL) else $error("halt ramp wrong");
	sd_hold_a: assert property (quiet_s and sd_brake_s and !stopped_s |=>
		r_q.state == S_READY) else $error("shutdown brake cut short");
	sd_done_a: assert property (quiet_s and sd_brake_s and stopped_s |=>
		r_q.state == S_SW_DISABLED) else $error("shutdown brake never ended");
	fault_ramp_a: assert property (!fatal_s && !r_q.fatal && fault_s &&
		r_q.state == S_OP_ENABLED && r_q.fault_opt == OPT_2 |=>
		r_q.state == S_FAULT_REACT && r_q.ramp == RAMP_QUICK) else $error("fault reaction wrong");
	qs_return_a: assert property (quiet_s and (r_q.state == S_QSTOP && qs_hold && qs_edge &&
		cmd_dec == C_ENABLE_OP) |=> r_q.state == S_OP_ENABLED)
		else $error("no return from quick stop");
endmodule : drive_psm

// ===== include/drive_psm_pkg.sv
// package of the drive power state machine: register map, state codes,
// reaction options and status word layout; assumes a 32-bit APB master
package drive_psm_pkg;
	// ---------------------------------------------------------------
	// register byte offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_CMD = 8'h00;
	localparam logic [7:0] OFS_STATE = 8'h04;
	localparam logic [7:0] OFS_MODE_REQ = 8'h08;
	localparam logic [7:0] OFS_MODE_ACT = 8'h0C;
	localparam logic [7:0] OFS_QS_OPT = 8'h10;
	localparam logic [7:0] OFS_SD_OPT = 8'h14;
	localparam logic [7:0] OFS_HALT_OPT = 8'h18;
	localparam logic [7:0] OFS_FAULT_OPT = 8'h1C;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
	// ---------------------------------------------------------------
	// reset values and field positions
	// ---------------------------------------------------------------
	localparam logic [15:0] RST_CMD = 16'h0000;
	localparam logic [15:0] RST_QS_OPT = 16'h0002;
	localparam logic [15:0] RST_SD_OPT = 16'h0001;
	localparam logic [15:0] RST_HALT_OPT = 16'h0001;
	localparam logic [15:0] RST_FAULT_OPT = 16'h0002;
	localparam logic [7:0] RST_MODE = 8'h00;
	localparam int CMD_HALT_BIT = 8;
	localparam int CMD_FRESET_BIT = 7;
	localparam int CMD_QSTOP_BIT = 2;
	localparam int ST_VOLT_BIT = 4;
	localparam int ST_HALT_BIT = 8;
	localparam int IRQ_W = 4;
	localparam int IRQ_STATE_CHG = 0;
	localparam int IRQ_FAULT = 1;
	localparam int IRQ_LIMIT = 2;
	localparam int IRQ_FATAL = 3;
	// ---------------------------------------------------------------
	// option values
	// ---------------------------------------------------------------
	localparam logic [15:0] OPT_0 = 16'h0000;
	localparam logic [15:0] OPT_1 = 16'h0001;
	localparam logic [15:0] OPT_2 = 16'h0002;
	localparam logic [15:0] OPT_5 = 16'h0005;
	localparam logic [15:0] OPT_6 = 16'h0006;
	// ramp select output codes
	localparam logic [1:0] RAMP_NONE = 2'h0;
	localparam logic [1:0] RAMP_DECEL = 2'h1;
	localparam logic [1:0] RAMP_QUICK = 2'h2;
	localparam logic [1:0] RAMP_IMMED = 2'h3;

	typedef enum logic [2:0] {
		S_NOT_READY, S_SW_DISABLED, S_READY, S_SWITCHED_ON,
		S_OP_ENABLED, S_QSTOP, S_FAULT_REACT, S_FAULT
	} drive_state_t;

	typedef enum logic [2:0] {
		C_NONE, C_SHUTDOWN, C_SWITCH_ON, C_DIS_VOLT, C_QSTOP, C_ENABLE_OP
	} drive_cmd_t;
endpackage : drive_psm_pkg

// ===== testbench/apb_master_model.sv
// APB master model standing in for the fieldbus master
// assumes: one clock, slave answers with pready at a rising edge
`timescale 1ns/1ns
module apb_master_model (
	input wire logic clk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end

	// ----------------------------------------
	// one transfer, held until pready is seen
	// ----------------------------------------
	// state changes are requested by register writes here and by the status pins the testbench drives
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released data flips so a stale value is never mistaken for valid
		pwdata <= ~d;
	endtask : xfer
endmodule : apb_master_model

// ===== testbench/drive_psm_tb.sv
// testbench of the drive power state machine, one task per scenario
// assumes: apb_master_model compiled first, package constants in scope
`timescale 1ns/1ns
module drive_psm_tb
	import drive_psm_pkg::*;
;
	localparam logic [31:0] M6 = 32'h6F;
	localparam logic [31:0] M4 = 32'h4F;
	localparam int LIMIT = 20000;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel, penable, pwrite, pready, pslverr, irq, pwr, ctl, halt;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [1:0] ramp;
	logic st_ok = 1'b0;
	logic fatal = 1'b0;
	logic fault = 1'b0;
	logic limit = 1'b0;
	logic stopped = 1'b0;
	int fails = 0;
	int checked = 0;
	int cycles = 0;

	always #5 clk = ~clk;

	drive_psm u_drive_psm (.CLK_SYS(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .SELFTEST_OK(st_ok), .FATAL_ERR(fatal),
		.FAULT_IN(fault), .LIMIT_SW(limit), .MOTOR_STOPPED(stopped), .POWER_EN(pwr),
		.CTRL_EN(ctl), .RAMP_SEL(ramp), .HALT_ACT(halt), .IRQ(irq));

	apb_master_model u_apb_master_model (.clk(clk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic close_out();
		$display("counts: checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : close_out

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			fails++;
			close_out();
		end
	end

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		u_apb_master_model.xfer(1'b1, a, d, r, e);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		u_apb_master_model.xfer(1'b0, a, 32'h0, r, e);
		cmp(r, exp);
	endtask : rdc

	// polls the state word; the pins pass synchronisers, so no fixed delay
	task automatic wait_st(input logic [31:0] exp, input logic [31:0] m);
		logic [31:0] r;
		logic e;
		int n;
		n = 0;
		do begin
			u_apb_master_model.xfer(1'b0, OFS_STATE, 32'h0, r, e);
			n++;
		end while ((r & m) !== exp && n < 40);
		cmp(r & m, exp);
	endtask : wait_st

	task automatic hold_st(input logic [31:0] exp, input logic [31:0] m);
		repeat (8) @(posedge clk);
		wait_st(exp, m);
	endtask : hold_st

	// starts from switch on disabled and steps through ready and switched on to op enabled
	task automatic go_oe();
		wr(OFS_CMD, 32'h0);
		wait_st(32'h40, M6);
		wr(OFS_CMD, 32'h6);
		wait_st(32'h21, M6);
		wr(OFS_CMD, 32'h7);
		wait_st(32'h23, M6);
		cmp(32'({pwr, ctl}), 32'h2);
		wr(OFS_CMD, 32'hF);
		wait_st(32'h27, M6);
		cmp(32'({pwr, ctl}), 32'h3);
	endtask : go_oe

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_boot();
		wait_st(32'h0, M4);
		rdc(OFS_QS_OPT, {16'h0, RST_QS_OPT});
		rdc(OFS_SD_OPT, {16'h0, RST_SD_OPT});
		rdc(OFS_HALT_OPT, {16'h0, RST_HALT_OPT});
		rdc(OFS_FAULT_OPT, {16'h0, RST_FAULT_OPT});
		st_ok <= 1'b1;
		wait_st(32'h40, M6);
		cmp(32'(irq), 32'h0);
		wr(OFS_CMD, 32'hF);
		hold_st(32'h40, M6);
		$display("test boot done");
	endtask : t_boot

	task automatic t_qs5();
		wr(OFS_QS_OPT, 32'h5);
		wr(OFS_IRQ_MASK, 32'h4);
		go_oe();
		limit <= 1'b1;
		wait_st(32'h07, M6);
		cmp(32'(irq), 32'h1);
		limit <= 1'b0;
		hold_st(32'h07, M6);
		cmp(32'({pwr, ctl}), 32'h3);
		wr(OFS_IRQ_STAT, 32'h4);
		@(posedge clk);
		cmp(32'(irq), 32'h0);
		wr(OFS_CMD, 32'hB);
		wr(OFS_CMD, 32'hF);
		wait_st(32'h27, M6);
		$display("test qs5 done");
	endtask : t_qs5

	task automatic t_qs02();
		wr(OFS_QS_OPT, 32'h0);
		go_oe();
		wr(OFS_CMD, 32'hB);
		wait_st(32'h40, M6);
		cmp(32'(pwr), 32'h0);
		wr(OFS_QS_OPT, 32'h2);
		go_oe();
		wr(OFS_CMD, 32'hB);
		wait_st(32'h07, M6);
		cmp(32'(ramp), 32'(RAMP_QUICK));
		stopped <= 1'b1;
		wait_st(32'h40, M6);
		stopped <= 1'b0;
		$display("test qs02 done");
	endtask : t_qs02

	task automatic t_shut_halt();
		go_oe();
		wr(OFS_CMD, 32'h6);
		wait_st(32'h21, M6);
		cmp(32'(ramp), 32'(RAMP_DECEL));
		wr(OFS_CMD, 32'h0);
		hold_st(32'h21, M6);
		stopped <= 1'b1;
		wait_st(32'h40, M6);
		stopped <= 1'b0;
		go_oe();
		wr(OFS_CMD, 32'h10F);
		repeat (2) @(posedge clk);
		cmp(32'(halt), 32'h1);
		cmp(32'(ramp), 32'(RAMP_DECEL));
		wr(OFS_CMD, 32'hF);
		repeat (2) @(posedge clk);
		cmp(32'(halt), 32'h0);
		$display("test shutdown and halt done");
	endtask : t_shut_halt

	task automatic t_fault();
		wr(OFS_CMD, 32'h8F);
		fault <= 1'b1;
		wait_st(32'h0F, M4);
		cmp(32'(ramp), 32'(RAMP_QUICK));
		stopped <= 1'b1;
		wait_st(32'h08, M4);
		stopped <= 1'b0;
		fault <= 1'b0;
		hold_st(32'h08, M4);
		wr(OFS_MODE_REQ, 32'h3);
		@(posedge clk);
		rdc(OFS_MODE_ACT, 32'h3);
		wr(OFS_CMD, 32'hF);
		wr(OFS_CMD, 32'h8F);
		wait_st(32'h40, M6);
		$display("test fault done");
	endtask : t_fault

	task automatic t_regs();
		logic [31:0] r;
		logic e;
		wr(OFS_MODE_ACT, 32'h7);
		rdc(OFS_MODE_ACT, 32'h3);
		rdc(OFS_MODE_REQ, 32'h3);
		u_apb_master_model.xfer(1'b0, 8'h28, 32'h0, r, e);
		cmp(r, 32'h0);
		cmp(32'(e), 32'h1);
		fatal <= 1'b1;
		wait_st(32'h0, M4);
		wr(OFS_CMD, 32'h6);
		hold_st(32'h0, M4);
		$display("test registers and fatal done");
	endtask : t_regs

	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t_boot();
		t_qs5();
		t_qs02();
		t_shut_halt();
		t_fault();
		t_regs();
		close_out();
	end
endmodule : drive_psm_tb
